// ### hdl/i2cm_pkg.sv
// Constants shared by the two-wire master bridge port.
package i2cm_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned BIT_RATE_BPS = 125_000;
   // Quarter bit time, rounded up so the bit rate never exceeds the limit.
   localparam int unsigned QUARTER_DIV = 4 * BIT_RATE_BPS;
   localparam int unsigned QUARTER_CYC =
      (CLK_HZ + QUARTER_DIV - 1) / QUARTER_DIV;
   localparam int unsigned QW = 6;
   localparam logic [QW-1:0] QUARTER_LAST = QW'(QUARTER_CYC - 1);
   localparam logic [QW-1:0] QCNT_ZERO    = 6'h00;

   localparam logic [1:0] PH_0 = 2'h0;
   localparam logic [1:0] PH_1 = 2'h1;
   localparam logic [1:0] PH_2 = 2'h2;
   localparam logic [1:0] PH_3 = 2'h3;

   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_ACK   = 4'h8;

   // Selection code of the interface-select pins that enables this master.
   localparam logic [2:0] SEL_I2C = 3'h3;

   // Command word: op in [10:8], byte in [7:0].
   localparam int unsigned CMD_W  = 11;
   localparam int unsigned OP_MSB = 10;
   localparam int unsigned OP_LSB = 8;
   localparam logic [2:0] OP_START     = 3'h1;
   localparam logic [2:0] OP_WRITE     = 3'h2;
   localparam logic [2:0] OP_READ_ACK  = 3'h3;
   localparam logic [2:0] OP_READ_NACK = 3'h4;
   localparam logic [2:0] OP_STOP      = 3'h5;

   // Answer word: error in [9], no-acknowledge in [8], byte in [7:0].
   localparam int unsigned RSP_W = 10;
   localparam logic [7:0] BYTE_ONES = 8'hff;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_BITS  = 5'h04,
      ST_STOP  = 5'h08,
      ST_RESP  = 5'h10
   } i2cm_state_t;
endpackage

// ### hdl/i2cm_bridge.sv
// Two-wire serial master carrying byte commands from the host data pipe.
// How it works
// - Engine acts on a command only when interface-select pins pick the two-wire master.
// - Both lines are only pulled low or released, never driven high.
// - Bit time is four quarters, keeping the rate at or under 125 kbit/s.
// - Each transfer opens with start, seven address bits, one direction bit.
// - Direction bit is 0 for write and 1 for read.
// - After address, master transmits or receives as direction bit said; here the command op decides and the bit is not checked.
// - Bytes shift onto the data line most significant bit first.
// - Start is data falling with clock high; stop is data rising.
// - On writes each byte is followed by a slave acknowledge slot.
// - On reads master acknowledges all bytes but the last.
// - Transfers end with stop or with a repeated start.
// - Every message opens with start and closes with stop.
// - Segments in a combined message use repeated start, no stop between.
`timescale 1ns/1ns
module i2cm_bridge (
   input  wire logic                        clk_sys_in,
   input  wire logic                        resetn_in,
   input  wire logic                        clk_pipe_in,
   input  wire logic [2:0]                  interface_select_pins_in,
   input  wire logic                        i2c_scl_in,
   output logic                             i2c_scl_out,
   output logic                             i2c_scl_oe_n_out,
   input  wire logic                        i2c_sda_in,
   output logic                             i2c_sda_out,
   output logic                             i2c_sda_oe_n_out,
   input  wire logic                        cmd_valid_in,
   input  wire logic [i2cm_pkg::CMD_W-1:0]  cmd_data_in,
   output logic                             cmd_ready_out,
   output logic                             rsp_valid_out,
   output logic [i2cm_pkg::RSP_W-1:0]       rsp_data_out,
   input  wire logic                        rsp_ready_in
);

   // Pipe-side reset: the reset pin is brought into the pipe clock first.
   logic                        prst_1;
   logic                        prst_2;
   // Pipe side state.
   logic                        cmd_rdy;
   logic                        cmd_tgl;
   logic [i2cm_pkg::CMD_W-1:0]  cmd_word;
   logic                        rs_1;
   logic                        rs_2;
   logic                        rs_seen;
   logic                        h_v;
   logic                        t_v;
   logic [i2cm_pkg::RSP_W-1:0]  h_d;
   logic [i2cm_pkg::RSP_W-1:0]  t_d;
   logic                        next_cmd_rdy;
   logic                        next_cmd_tgl;
   logic [i2cm_pkg::CMD_W-1:0]  next_cmd_word;
   logic                        next_rs_seen;
   logic                        next_h_v;
   logic                        next_t_v;
   logic [i2cm_pkg::RSP_W-1:0]  next_h_d;
   logic [i2cm_pkg::RSP_W-1:0]  next_t_d;
   logic                        push;
   logic                        pop;

   // System side synchronisers.
   logic                        cs_1;
   logic                        cs_2;
   logic                        cs_3;
   logic [2:0]                  sel_1;
   logic [2:0]                  sel_2;
   logic                        scl_1;
   logic                        scl_s;
   logic                        sda_1;
   logic                        sda_s;

   // Engine state.
   i2cm_pkg::i2cm_state_t       state;
   i2cm_pkg::i2cm_state_t       next_state;
   logic [i2cm_pkg::QW-1:0]     qcnt;
   logic [i2cm_pkg::QW-1:0]     next_qcnt;
   logic [1:0]                  phase;
   logic [1:0]                  next_phase;
   logic [3:0]                  bitn;
   logic [3:0]                  next_bitn;
   logic [7:0]                  shreg;
   logic [7:0]                  next_shreg;
   logic [2:0]                  op;
   logic [2:0]                  next_op;
   logic                        err;
   logic                        next_err;
   logic                        nack;
   logic                        next_nack;
   logic                        opened;
   logic                        next_opened;
   logic                        scl_rel;
   logic                        next_scl_rel;
   logic                        sda_rel;
   logic                        next_sda_rel;
   logic                        rsp_tgl;
   logic                        next_rsp_tgl;
   logic [i2cm_pkg::RSP_W-1:0]  rsp_word;
   logic [i2cm_pkg::RSP_W-1:0]  next_rsp_word;
   logic                        pin_low;
   logic                        cmd_new;
   logic                        is_read;
   logic                        tick;
   logic                        adv;
   logic                        tx_bit;

   // ---------------- Pipe clock domain ----------------
   always_ff @(posedge clk_pipe_in)
   begin
      prst_1 <= resetn_in;
      prst_2 <= prst_1;
   end

   // Both toggles carry a held word, so only the toggle needs synchronising.
   always_ff @(posedge clk_pipe_in)
   begin
      rs_1 <= rsp_tgl;
      rs_2 <= rs_1;
   end

   always_comb
   begin
      pop  = h_v && rsp_ready_in;
      // A full buffer leaves the answer pending, which keeps the command
      // port stalled; no answer is ever dropped.
      push = (rs_2 != rs_seen) && !t_v;
      next_cmd_rdy  = cmd_rdy;
      next_cmd_tgl  = cmd_tgl;
      next_cmd_word = cmd_word;
      next_rs_seen  = rs_seen;
      next_h_v = h_v;
      next_h_d = h_d;
      next_t_v = t_v;
      next_t_d = t_d;
      if (cmd_valid_in && cmd_rdy)
      begin
         next_cmd_word = cmd_data_in;
         next_cmd_tgl  = !cmd_tgl;
         next_cmd_rdy  = 1'b0;
      end
      if (pop)
      begin
         next_h_v = t_v;
         next_h_d = t_d;
         next_t_v = 1'b0;
      end
      if (push)
      begin
         next_rs_seen = rs_2;
         next_cmd_rdy = 1'b1;
         if (!next_h_v)
         begin
            next_h_v = 1'b1;
            next_h_d = rsp_word;
         end
         else
         begin
            next_t_v = 1'b1;
            next_t_d = rsp_word;
         end
      end
   end

   always_ff @(posedge clk_pipe_in)
   begin
      if (!prst_2)
      begin
         cmd_rdy  <= 1'b1;
         cmd_tgl  <= 1'b0;
         cmd_word <= '0;
         rs_seen  <= 1'b0;
         h_v      <= 1'b0;
         h_d      <= '0;
         t_v      <= 1'b0;
         t_d      <= '0;
      end
      else
      begin
         cmd_rdy  <= next_cmd_rdy;
         cmd_tgl  <= next_cmd_tgl;
         cmd_word <= next_cmd_word;
         rs_seen  <= next_rs_seen;
         h_v      <= next_h_v;
         h_d      <= next_h_d;
         t_v      <= next_t_v;
         t_d      <= next_t_d;
      end
   end

   assign cmd_ready_out = cmd_rdy;
   assign rsp_valid_out = h_v;
   assign rsp_data_out  = h_d;

   // ---------------- System clock domain ----------------
   always_ff @(posedge clk_sys_in)
   begin
      cs_1  <= cmd_tgl;
      cs_2  <= cs_1;
      sel_1 <= interface_select_pins_in;
      sel_2 <= sel_1;
      scl_1 <= i2c_scl_in;
      scl_s <= scl_1;
      sda_1 <= i2c_sda_in;
      sda_s <= sda_1;
   end

   always_comb
   begin
      cmd_new = (cs_2 != cs_3);
      is_read = (op == i2cm_pkg::OP_READ_ACK) ||
                (op == i2cm_pkg::OP_READ_NACK);
      tick = (qcnt == i2cm_pkg::QUARTER_LAST);
      // A start from an unopened bus waits until both lines sit high, and
      // every clock-high phase waits out a slave holding the clock low.
      adv = tick && !(phase == i2cm_pkg::PH_2 && !scl_s) &&
            !(state == i2cm_pkg::ST_START && phase == i2cm_pkg::PH_2 &&
              !opened && !sda_s);
      if (bitn == i2cm_pkg::BIT_ACK)
         tx_bit = is_read ? (op == i2cm_pkg::OP_READ_NACK) : 1'b1;
      else
         tx_bit = is_read ? 1'b1 : shreg[7];
      next_state    = state;
      next_qcnt     = adv ? i2cm_pkg::QCNT_ZERO : qcnt;
      next_phase    = adv ? phase + 2'h1 : phase;
      next_bitn     = bitn;
      next_shreg    = shreg;
      next_op       = op;
      next_err      = err;
      next_nack     = nack;
      next_opened   = opened;
      next_scl_rel  = scl_rel;
      next_sda_rel  = sda_rel;
      next_rsp_tgl  = rsp_tgl;
      next_rsp_word = rsp_word;
      if (!tick)
         next_qcnt = qcnt + 6'h01;
      case (state)
         i2cm_pkg::ST_IDLE:
         begin
            next_qcnt  = i2cm_pkg::QCNT_ZERO;
            next_phase = i2cm_pkg::PH_0;
            next_bitn  = i2cm_pkg::BIT_FIRST;
            if (cmd_new)
            begin
               next_op    = cmd_word[i2cm_pkg::OP_MSB:i2cm_pkg::OP_LSB];
               next_shreg = cmd_word[7:0];
               next_err   = 1'b0;
               next_nack  = 1'b0;
               next_state = i2cm_pkg::ST_RESP;
               if (sel_2 != i2cm_pkg::SEL_I2C)
                  next_err = 1'b1;
               else
               begin
                  case (next_op)
                     // Address byte carries the direction bit in its lsb.
                     i2cm_pkg::OP_START:
                        next_state = i2cm_pkg::ST_START;
                     i2cm_pkg::OP_WRITE:
                     begin
                        next_state = opened ? i2cm_pkg::ST_BITS
                                            : i2cm_pkg::ST_RESP;
                        next_err   = !opened;
                     end
                     i2cm_pkg::OP_READ_ACK,
                     i2cm_pkg::OP_READ_NACK:
                     begin
                        next_state = opened ? i2cm_pkg::ST_BITS
                                            : i2cm_pkg::ST_RESP;
                        next_err   = !opened;
                        next_shreg = i2cm_pkg::BYTE_ONES;
                     end
                     i2cm_pkg::OP_STOP:
                        next_state = opened ? i2cm_pkg::ST_STOP
                                            : i2cm_pkg::ST_RESP;
                     default:
                        next_err = 1'b1;
                  endcase
               end
            end
         end
         i2cm_pkg::ST_START:
         begin
            // From an open message this is a repeated start with no stop.
            if (adv)
            begin
               case (phase)
                  i2cm_pkg::PH_0: next_sda_rel = 1'b1;
                  i2cm_pkg::PH_1: next_scl_rel = 1'b1;
                  i2cm_pkg::PH_2: next_sda_rel = 1'b0;
                  default:
                  begin
                     next_scl_rel = 1'b0;
                     next_opened  = 1'b1;
                     next_state   = i2cm_pkg::ST_BITS;
                  end
               endcase
            end
         end
         i2cm_pkg::ST_BITS:
         begin
            if (adv)
            begin
               case (phase)
                  i2cm_pkg::PH_0: next_sda_rel = tx_bit;
                  i2cm_pkg::PH_1: next_scl_rel = 1'b1;
                  i2cm_pkg::PH_2:
                  begin
                     if (bitn != i2cm_pkg::BIT_ACK)
                        next_shreg = {shreg[6:0], sda_s};
                     else if (!is_read)
                        next_nack = sda_s;
                  end
                  default:
                  begin
                     next_scl_rel = 1'b0;
                     next_bitn    = bitn + 4'h1;
                     if (bitn == i2cm_pkg::BIT_ACK)
                     begin
                        next_sda_rel = 1'b1;
                        next_state   = nack ? i2cm_pkg::ST_STOP
                                            : i2cm_pkg::ST_RESP;
                        next_err     = nack;
                     end
                  end
               endcase
            end
         end
         i2cm_pkg::ST_STOP:
         begin
            // The last quarter doubles as bus free time before any start.
            if (adv)
            begin
               case (phase)
                  i2cm_pkg::PH_0: next_sda_rel = 1'b0;
                  i2cm_pkg::PH_1: next_scl_rel = 1'b1;
                  i2cm_pkg::PH_2: next_sda_rel = 1'b1;
                  default:
                  begin
                     next_opened = 1'b0;
                     next_state  = i2cm_pkg::ST_RESP;
                  end
               endcase
            end
         end
         i2cm_pkg::ST_RESP:
         begin
            next_rsp_word = {err, nack, shreg};
            next_rsp_tgl  = !rsp_tgl;
            next_state    = i2cm_pkg::ST_IDLE;
         end
         default:
            next_state = i2cm_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         cs_3     <= 1'b0;
         state    <= i2cm_pkg::ST_IDLE;
         qcnt     <= i2cm_pkg::QCNT_ZERO;
         phase    <= i2cm_pkg::PH_0;
         bitn     <= i2cm_pkg::BIT_FIRST;
         shreg    <= '0;
         op       <= '0;
         err      <= 1'b0;
         nack     <= 1'b0;
         opened   <= 1'b0;
         scl_rel  <= 1'b1;
         sda_rel  <= 1'b1;
         rsp_tgl  <= 1'b0;
         rsp_word <= '0;
         pin_low  <= 1'b0;
      end
      else
      begin
         cs_3     <= cs_2;
         state    <= next_state;
         qcnt     <= next_qcnt;
         phase    <= next_phase;
         bitn     <= next_bitn;
         shreg    <= next_shreg;
         op       <= next_op;
         err      <= next_err;
         nack     <= next_nack;
         opened   <= next_opened;
         scl_rel  <= next_scl_rel;
         sda_rel  <= next_sda_rel;
         rsp_tgl  <= next_rsp_tgl;
         rsp_word <= next_rsp_word;
         pin_low  <= 1'b0;
      end
   end

   assign i2c_scl_out      = pin_low;
   assign i2c_scl_oe_n_out = scl_rel;
   assign i2c_sda_out      = pin_low;
   assign i2c_sda_oe_n_out = sda_rel;

endmodule

// ### bench/i2cm_bridge_properties.sv
// Checker of the two-wire master bridge port at its pins.
`timescale 1ns/1ns
module i2cm_bridge_properties (
   input wire logic        clk_sys_in,
   input wire logic        resetn_in,
   input wire logic        clk_pipe_in,
   input wire logic [2:0]  interface_select_pins_in,
   input wire logic        i2c_scl_in,
   input wire logic        i2c_scl_out,
   input wire logic        i2c_scl_oe_n_out,
   input wire logic        i2c_sda_in,
   input wire logic        i2c_sda_out,
   input wire logic        i2c_sda_oe_n_out,
   input wire logic        cmd_valid_in,
   input wire logic [10:0] cmd_data_in,
   input wire logic        cmd_ready_out,
   input wire logic        rsp_valid_out,
   input wire logic [9:0]  rsp_data_out,
   input wire logic        rsp_ready_in
);
   logic       last_scl;
   logic [7:0] hold;
   logic [7:0] next_hold;
   // Saturates so a long idle bus never wraps back under the limit.
   always_comb
   begin
      next_hold = hold;
      if (i2c_scl_oe_n_out != last_scl)
         next_hold = 8'h00;
      else if (hold != 8'hff)
         next_hold = hold + 8'h01;
   end
   always_ff @(posedge clk_sys_in)
   begin
      last_scl <= resetn_in ? i2c_scl_oe_n_out : 1'b1;
      hold     <= resetn_in ? next_hold : 8'hff;
   end
   a_pins_low: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) !i2c_scl_out && !i2c_sda_out)
      else $error("pin driven high");
   a_scl_quarters: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) $changed(i2c_scl_oe_n_out) |-> hold >= 8'h4f)
      else $error("clock phase shorter than two quarters");
   a_start_clock_high: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) $fell(i2c_sda_oe_n_out) && i2c_scl_oe_n_out
      |-> i2c_scl_in ##1 i2c_scl_oe_n_out [*8])
      else $error("start without clock high");
   a_stop_clock_high: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in) $rose(i2c_sda_oe_n_out) && i2c_scl_oe_n_out
      |-> i2c_scl_in ##1 (i2c_scl_oe_n_out && i2c_sda_oe_n_out) [*8])
      else $error("stop not followed by idle bus");
   a_sel_quiet: assert property (@(posedge clk_sys_in)
      disable iff (!resetn_in)
      interface_select_pins_in != i2cm_pkg::SEL_I2C && i2c_scl_oe_n_out &&
      i2c_sda_oe_n_out |=> i2c_scl_oe_n_out && i2c_sda_oe_n_out)
      else $error("bus moved while not selected");
   a_nack_release: assert property (@(posedge clk_pipe_in)
      disable iff (!resetn_in) $rose(rsp_valid_out) && rsp_data_out[8]
      |-> rsp_data_out[9] && i2c_scl_oe_n_out && i2c_sda_oe_n_out)
      else $error("no-ack answer without error and stop");
   a_one_cmd: assert property (@(posedge clk_pipe_in)
      disable iff (!resetn_in) cmd_valid_in && cmd_ready_out |=> !cmd_ready_out)
      else $error("second command taken while busy");
   a_rsp_stands: assert property (@(posedge clk_pipe_in)
      disable iff (!resetn_in) rsp_valid_out && !rsp_ready_in
      |=> rsp_valid_out && $stable(rsp_data_out))
      else $error("answer dropped before taken");
endmodule

// ### bench/i2cm_slave_model.sv
// Behavioural two-wire slave answering one address on pulled-up wires.
`timescale 1ns/1ns
module i2cm_slave_model #(
   parameter logic [6:0] ADDR = 7'h2c
) (
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   output logic       sda_oe_n_out,
   output logic [7:0] addr_out,
   output logic [7:0] wr_out,
   output logic       mack_out
);
   logic [7:0] sh;
   logic [7:0] rd = 8'ha5;
   logic       first = 1'b0;
   logic       act = 1'b0;
   logic       rdm = 1'b0;
   int         n = 0;
   // The model only ever pulls low or releases the data line.
   initial sda_oe_n_out = 1'b1;
   initial mack_out = 1'b1;
   always @(sda_in)
   begin
      if (scl_in === 1'b1)
      begin
         n = 0;
         first = !sda_in;
         act = 1'b0;
         rdm = 1'b0;
         sda_oe_n_out = 1'b1;
      end
   end
   always @(posedge scl_in)
   begin
      if (n < 8)
         sh = {sh[6:0], sda_in};
      else if (rdm)
      begin
         mack_out = sda_in;
         rdm = !sda_in;
      end
      n = n + 1;
   end
   always @(negedge scl_in)
   begin
      sda_oe_n_out = 1'b1;
      if (n == 8 && first)
      begin
         addr_out = sh;
         act = (sh[7:1] == ADDR);
         rdm = act && sh[0];
         first = 1'b0;
         sda_oe_n_out = !act;
      end
      else if (n == 8 && act && !rdm)
      begin
         wr_out = sh;
         sda_oe_n_out = 1'b0;
      end
      else if (rdm && n == 8)
         rd = rd + 8'h01;
      else if (rdm)
      begin
         if (n == 9)
            n = 0;
         sda_oe_n_out = rd[7 - n];
      end
      else if (n == 9)
         n = 0;
   end
endmodule

// ### bench/testbench.sv
// Self-checking bench of the two-wire master bridge port.
`timescale 1ns/1ns
module testbench;
   localparam logic [6:0] ADDR = 7'h2c;
   logic        clk_sys = 1'b0;
   logic        clk_pipe = 1'b0;
   logic        resetn = 1'b0;
   logic [2:0]  sel = 3'h3;
   logic        cmd_valid = 1'b0;
   logic [10:0] cmd_data = 11'h000;
   logic        rsp_ready = 1'b0;
   logic [9:0]  r;
   wire         scl_oe_n, sda_oe_n, slv_oe_n, cmd_ready, rsp_valid, mack;
   wire  [9:0]  rsp_data;
   wire  [7:0]  slv_addr, slv_wr;
   wire         scl = scl_oe_n;
   wire         sda = sda_oe_n & slv_oe_n;
   int          miscompares = 0;
   int          checks = 0;
   int          starts = 0;
   int          stops = 0;
   initial forever #25 clk_sys = ~clk_sys;
   initial #3 forever #6 clk_pipe = ~clk_pipe;
   always @(negedge sda) if (scl === 1'b1) starts++;
   always @(posedge sda) if (scl === 1'b1) stops++;
   i2cm_bridge DUT (.clk_sys_in(clk_sys), .resetn_in(resetn),
      .clk_pipe_in(clk_pipe), .interface_select_pins_in(sel),
      .i2c_scl_in(scl), .i2c_scl_out(), .i2c_scl_oe_n_out(scl_oe_n),
      .i2c_sda_in(sda), .i2c_sda_out(), .i2c_sda_oe_n_out(sda_oe_n),
      .cmd_valid_in(cmd_valid), .cmd_data_in(cmd_data),
      .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data), .rsp_ready_in(rsp_ready));
   i2cm_slave_model #(.ADDR(ADDR)) u_slave (.scl_in(scl), .sda_in(sda),
      .sda_oe_n_out(slv_oe_n), .addr_out(slv_addr), .wr_out(slv_wr),
      .mack_out(mack));
   task automatic chk(input string what, input logic [9:0] exp,
                      input logic [9:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Holds the request until the edge that samples ready high.
   task automatic send(input logic [2:0] o, input logic [7:0] b);
      int t = 0;
      @(negedge clk_pipe);
      cmd_valid = 1'b1;
      cmd_data = {o, b};
      do @(posedge clk_pipe); while (cmd_ready !== 1'b1 && t++ < 40000);
      // A command port that never frees up ends the run as a failure.
      if (t > 40000)
      begin
         miscompares++;
         results();
      end
      @(negedge clk_pipe);
      cmd_valid = 1'b0;
   endtask
   task automatic take(output logic [9:0] d);
      int t = 0;
      @(negedge clk_pipe);
      rsp_ready = 1'b1;
      do @(posedge clk_pipe); while (rsp_valid !== 1'b1 && t++ < 40000);
      if (t > 40000)
      begin
         miscompares++;
         results();
      end
      d = rsp_data;
      @(negedge clk_pipe);
      rsp_ready = 1'b0;
   endtask
   task automatic fl(input logic [2:0] o, input logic [7:0] b,
                     input logic [1:0] e);
      send(o, b);
      take(r);
      chk("answer flags", {8'h00, e}, {8'h00, r[9:8]});
   endtask
   task automatic er(input logic [2:0] o, input logic [7:0] b);
      send(o, b);
      take(r);
      chk("error bit", 10'h001, {9'h000, r[9]});
   endtask
   task automatic t_reset();
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (12) @(negedge clk_sys);
      resetn = 1'b1;
      chk("lines released", 10'h003, {8'h00, scl_oe_n, sda_oe_n});
      chk("pipe idle", 10'h002, {8'h00, cmd_ready, rsp_valid});
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic t_write();
      int p0 = stops;
      fl(i2cm_pkg::OP_START, {ADDR, 1'b0}, 2'h0);
      chk("address", {2'h0, ADDR, 1'b0}, {2'h0, slv_addr});
      fl(i2cm_pkg::OP_WRITE, 8'h96, 2'h0);
      chk("written byte", 10'h096, {2'h0, slv_wr});
      fl(i2cm_pkg::OP_WRITE, 8'h01, 2'h0);
      chk("second byte", 10'h001, {2'h0, slv_wr});
      fl(i2cm_pkg::OP_STOP, 8'h00, 2'h0);
      chk("stop count", 10'h001, 10'(stops - p0));
      chk("bus idle", 10'h003, {8'h00, scl, sda});
   endtask
   task automatic t_combined();
      int s0 = starts;
      int p0 = stops;
      fl(i2cm_pkg::OP_START, {ADDR, 1'b0}, 2'h0);
      fl(i2cm_pkg::OP_WRITE, 8'h10, 2'h0);
      fl(i2cm_pkg::OP_START, {ADDR, 1'b1}, 2'h0);
      chk("read address", {2'h0, ADDR, 1'b1}, {2'h0, slv_addr});
      chk("no stop between", 10'h000, 10'(stops - p0));
      send(i2cm_pkg::OP_READ_ACK, 8'h00);
      take(r);
      chk("first read", 10'h0a5, r);
      chk("master ack", 10'h000, {9'h000, mack});
      send(i2cm_pkg::OP_READ_NACK, 8'h00);
      take(r);
      chk("last read", 10'h0a6, {2'h0, r[7:0]});
      chk("master nack", 10'h001, {9'h000, mack});
      fl(i2cm_pkg::OP_STOP, 8'h00, 2'h0);
      chk("starts", 10'h002, 10'(starts - s0));
      chk("stops", 10'h001, 10'(stops - p0));
   endtask
   task automatic t_nack();
      int p0 = stops;
      fl(i2cm_pkg::OP_START, {7'h13, 1'b0}, 2'h3);
      chk("stop after no-ack", 10'h001, 10'(stops - p0));
      er(i2cm_pkg::OP_WRITE, 8'h55);
   endtask
   task automatic t_refuse();
      int s0 = starts;
      for (int o = 0; o < 8; o++)
         if (o == 0 || o > 5)
            er(3'(o), 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk_sys);
         sel = 3'(i);
         if (i != 3)
            er(i2cm_pkg::OP_START, {ADDR, 1'b0});
      end
      @(negedge clk_sys);
      sel = i2cm_pkg::SEL_I2C;
      chk("no start", 10'h000, 10'(starts - s0));
   endtask
   // Stalls the answer side so both buffer entries fill and the third
   // answer is held back, keeping the command port stalled; no answer may be lost.
   task automatic t_buffer();
      send(i2cm_pkg::OP_STOP, 8'h00);
      send(i2cm_pkg::OP_STOP, 8'h00);
      send(i2cm_pkg::OP_STOP, 8'h00);
      repeat (200) @(negedge clk_pipe);
      chk("buffer full", 10'h001, {8'h00, cmd_ready, rsp_valid});
      take(r);
      chk("first answer", 10'h000, {9'h000, r[9]});
      take(r);
      chk("second answer", 10'h000, {9'h000, r[9]});
      take(r);
      chk("third answer", 10'h000, {9'h000, r[9]});
      chk("drained", 10'h002, {8'h00, cmd_ready, rsp_valid});
   endtask
   task automatic t_midreset();
      send(i2cm_pkg::OP_START, {ADDR, 1'b0});
      repeat (300) @(negedge clk_sys);
      t_reset();
      fl(i2cm_pkg::OP_START, {ADDR, 1'b0}, 2'h0);
      fl(i2cm_pkg::OP_STOP, 8'h00, 2'h0);
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      t_reset();
      t_write();
      t_combined();
      t_nack();
      t_refuse();
      t_buffer();
      t_midreset();
      results();
   end
   initial
   begin
      #2_000_000;
      miscompares++;
      results();
   end
endmodule
bind i2cm_bridge i2cm_bridge_properties u_props (.clk_sys_in, .resetn_in,
   .clk_pipe_in, .interface_select_pins_in, .i2c_scl_in, .i2c_scl_out,
   .i2c_scl_oe_n_out, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe_n_out,
   .cmd_valid_in, .cmd_data_in, .cmd_ready_out, .rsp_valid_out,
   .rsp_data_out, .rsp_ready_in);
